/* File: dv/lcps_operator.sv */
// Operator model: rotary selector and momentary paddle
`timescale 1ns/1ns
module lcps_operator
  import lcps_pkg::*;
#(
  parameter int HOLD = 12
) (
  input wire logic clk,
  output logic [3:0] func_pos,
  output logic func_bank,
  output logic paddle_up,
  output logic paddle_dn
);
  initial begin
    func_pos = POS_IDLE;
    func_bank = 1'b1;
    paddle_up = 1'b0;
    paddle_dn = 1'b0;
  end
  task automatic select(input logic bank, input logic [3:0] pos);
    @(posedge clk);
    func_bank <= bank;
    func_pos <= pos;
  endtask : select
  // Contact bounce only when a test asks for it
  task automatic press(input logic bank, input logic [3:0] pos,
                       input logic up, input int glitch);
    select(bank, pos);
    if (glitch > 0) begin
      paddle_up <= up;
      paddle_dn <= !up;
      repeat (glitch) @(posedge clk);
      paddle_up <= 1'b0;
      paddle_dn <= 1'b0;
      repeat (3) @(posedge clk);
    end
    paddle_up <= up;
    paddle_dn <= !up;
    repeat (HOLD) @(posedge clk);
    paddle_up <= 1'b0;
    paddle_dn <= 1'b0;
    repeat (HOLD) @(posedge clk);
    select(1'b1, POS_IDLE);
  endtask : press
endmodule : lcps_operator

/* File: dv/tb_lcps_store.sv */
// Self-checking bench for the configuration store
`timescale 1ns/1ns
module tb_lcps_store;
  import lcps_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic [3:0] func_pos;
  logic func_bank, paddle_up, paddle_dn;
  logic jumper = 0, det625 = 0, ref_ok = 1;
  logic [7:0] addr = 0;
  logic [31:0] wr_data = 0, rd_data, rd_val, snap;
  logic wr_strobe = 0, rd_strobe = 0;
  logic bank_led, config_activity_led_led, line_625, lock_video, delay_mode, xcr;
  logic test_lin, test_mode;
  logic [7:0] fine;
  logic [10:0] hdly;
  logic [9:0] vdly;
  wire [4:0] frz;
  int miscompares = 0, checks = 0;
  always #25 clk = ~clk;
  lcps_operator #(.HOLD(12)) u_lcps_operator (.clk(clk),
    .func_pos(func_pos), .func_bank(func_bank), .paddle_up(paddle_up),
    .paddle_dn(paddle_dn));
  lcps_store #(.DEBOUNCE_CYC(4)) u_lcps_store (.clk(clk), .reset(reset),
    .func_pos(func_pos), .func_bank(func_bank), .paddle_up(paddle_up),
    .paddle_dn(paddle_dn), .remote_lockout_jumper(jumper),
    .detected_625(det625), .reference_present(ref_ok), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .bank_select_led(bank_led),
    .config_activity_led(config_activity_led_led), .fine_delay(fine), .h_delay(hdly),
    .v_delay(vdly), .line_625(line_625), .lock_to_video(lock_video),
    .delay_mode(delay_mode), .cross_colour_removal(xcr),
    .test_linearity(test_lin), .test_mode(test_mode),
    .freeze_auto(frz[0]), .freeze_force(frz[1]),
    .freeze_field_mode(frz[2]), .freeze_field2(frz[3]),
    .freeze_black(frz[4]));
  task automatic complete_run;
    $display("Counts: %0d checks, %0d miscompares", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 rd_val = rd_data;
  endtask : rd
  task automatic act(input logic b, input logic [3:0] p, input logic up);
    u_lcps_operator.press(b, p, up, 0);
    #1;
  endtask : act
  function automatic logic [31:0] clamp(input logic [31:0] v, mx);
    return (v > mx) ? mx : v;
  endfunction : clamp
  function automatic logic [31:0] flags();
    return {frz, lock_video, delay_mode, xcr, test_lin, test_mode};
  endfunction : flags
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    int n;
    void'($urandom(88));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check(config_activity_led_led, 1);
    check({fine, hdly, vdly}, 0);
    check(flags(), 0);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      u_lcps_operator.select(r[4], r[3:0]);
      @(posedge clk);
      #1;
      check(bank_led, r[4]);
      rd(REG_STATUS);
      check(rd_val[4:0], r[4:0]);
    end
    rd(8'h20);
    check(rd_val, 0);
    $display("test selector done");
    u_lcps_operator.press(1'b1, POS_1, 1'b1, 2);
    #1;
    check(fine, 1);
    act(1'b1, POS_1, 1'b0);
    act(1'b1, POS_1, 1'b0);
    check(fine, 0);
    r = $urandom_range(0, 255);
    wr(REG_FINE, r);
    rd(REG_FINE);
    check(rd_val, r);
    wr(REG_FINE, 32'hff);
    act(1'b1, POS_1, 1'b1);
    check(fine, FINE_MAX);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      det625 <= s[0];
      wr(REG_HDLY, 32'h7ff);
      check(hdly, clamp(32'h7ff, s ? HDLY_MAX_625 : HDLY_MAX_525));
      wr(REG_VDLY, 32'h3ff);
      check(vdly, clamp(32'h3ff, s ? VDLY_MAX_625 : VDLY_MAX_525));
    end
    act(1'b1, POS_3, 1'b0);
    check(vdly, VDLY_MAX_625 - 1);
    $display("test delays done");
    act(1'b1, POS_0, 1'b1);
    check({lock_video, delay_mode}, 2'b11);
    act(1'b1, POS_0, 1'b0);
    check({lock_video, delay_mode}, 2'b00);
    @(posedge clk);
    ref_ok <= 1'b0;
    @(posedge clk);
    #1;
    check(delay_mode, 1);
    @(posedge clk);
    ref_ok <= 1'b1;
    act(1'b0, POS_0, 1'b0);
    check(line_625, 0);
    act(1'b0, POS_1, 1'b0);
    check(line_625, 1);
    act(1'b0, POS_1, 1'b1);
    check(line_625, 0);
    act(1'b0, POS_0, 1'b1);
    check(line_625, 1);
    act(1'b1, POS_A, 1'b1);
    check(xcr, 1);
    act(1'b1, POS_C, 1'b0);
    act(1'b1, POS_D, 1'b1);
    check({test_lin, test_mode}, 2'b11);
    act(1'b1, POS_4, 1'b0);
    act(1'b1, POS_5, 1'b0);
    act(1'b1, POS_6, 1'b1);
    act(1'b1, POS_7, 1'b0);
    act(1'b1, POS_8, 1'b0);
    check(frz, 5'h1f);
    snap = {fine, hdly, vdly};
    r = flags();
    act(1'b1, POS_IDLE, 1'b1);
    act(1'b1, POS_IDLE, 1'b0);
    check({fine, hdly, vdly}, snap);
    check(flags(), r);
    $display("test flags done");
    @(posedge clk);
    jumper <= 1'b1;
    wr(REG_FINE, 32'h33);
    check(fine, FINE_MAX);
    act(1'b1, POS_1, 1'b0);
    check(fine, FINE_MAX - 1);
    @(posedge clk);
    jumper <= 1'b0;
    wr(REG_FINE, 32'h33);
    check(fine, 8'h33);
    wr(REG_FLAGS, 32'h7ff);
    rd(REG_FLAGS);
    check(rd_val, 32'h7ff);
    check(flags(), 32'h3ff);
    check(line_625, 1);
    @(posedge clk);
    #1;
    check(rd_data, 0);
    $display("test lockout done");
    act(0, POS_RECALL, 1'b0);
    check({fine, hdly, vdly}, 0);
    check(flags(), 0);
    check(config_activity_led_led, 1);
    n = 0;
    while (config_activity_led_led === 1'b1 && n < 2500) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 2500) begin
      miscompares++;
    end
    check(n >= BUSY_CYC - 40 && n <= BUSY_CYC, 1);
    $display("test recall done");
    complete_run();
  end
endmodule : tb_lcps_store

/* File: hdl/lcps_pkg.sv */
// Constants for the local configuration parameter store
package lcps_pkg;
  // Clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYC_DFLT = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int BUSY_US = 100;
  localparam int BUSY_CYC = BUSY_US * (CLK_HZ / 1_000_000);
  localparam int BUSY_W = 12;
  // Fine delay: 0.16 ns steps up to 40.80 ns
  localparam int FINE_STEP_PS = 160;
  localparam int FINE_MAX_PS = 40800;
  localparam logic [7:0] FINE_MAX = 8'(FINE_MAX_PS / FINE_STEP_PS);
  // Horizontal delay: 37 ns steps
  localparam int HDLY_STEP_NS = 37;
  localparam int HDLY_MAX_525_NS = 63418;
  localparam int HDLY_MAX_625_NS = 63862;
  localparam logic [10:0] HDLY_MAX_525 = 11'(HDLY_MAX_525_NS / HDLY_STEP_NS);
  localparam logic [10:0] HDLY_MAX_625 = 11'(HDLY_MAX_625_NS / HDLY_STEP_NS);
  // Vertical delay in lines
  localparam logic [9:0] VDLY_MAX_525 = 10'd524;
  localparam logic [9:0] VDLY_MAX_625 = 10'd624;
  // Reset values
  localparam logic [7:0] FINE_RST = 8'h00;
  localparam logic [10:0] HDLY_RST = 11'h000;
  localparam logic [9:0] VDLY_RST = 10'h000;
  localparam int FLG_W = 11;
  localparam logic [FLG_W-1:0] FLAGS_RST = 11'h000;
  // Flag bit positions
  localparam int FLG_LOCK_VIDEO = 0;
  localparam int FLG_XCR = 1;
  localparam int FLG_TEST_LIN = 2;
  localparam int FLG_TEST_EN = 3;
  localparam int FLG_FRZ_AUTO = 4;
  localparam int FLG_FRZ_FORCE = 5;
  localparam int FLG_FRZ_FIELD = 6;
  localparam int FLG_FRZ_F2 = 7;
  localparam int FLG_FRZ_BLACK = 8;
  localparam int FLG_STD_MANUAL = 9;
  localparam int FLG_STD_625 = 10;
  // Register offsets
  localparam logic [7:0] REG_FINE = 8'h00;
  localparam logic [7:0] REG_HDLY = 8'h04;
  localparam logic [7:0] REG_VDLY = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // Rotary positions
  localparam logic [3:0] POS_0 = 4'h0;
  localparam logic [3:0] POS_1 = 4'h1;
  localparam logic [3:0] POS_2 = 4'h2;
  localparam logic [3:0] POS_3 = 4'h3;
  localparam logic [3:0] POS_4 = 4'h4;
  localparam logic [3:0] POS_5 = 4'h5;
  localparam logic [3:0] POS_6 = 4'h6;
  localparam logic [3:0] POS_7 = 4'h7;
  localparam logic [3:0] POS_8 = 4'h8;
  localparam logic [3:0] POS_A = 4'ha;
  localparam logic [3:0] POS_C = 4'hc;
  localparam logic [3:0] POS_D = 4'hd;
  localparam logic [3:0] POS_IDLE = 4'he;
  localparam logic [3:0] POS_RECALL = 4'hf;
endpackage : lcps_pkg

/* File: hdl/lcps_store.sv */
// Configuration store with rotary/paddle front end and register port
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module lcps_store
  import lcps_pkg::*;
#(
  parameter int DEBOUNCE_CYC = DEBOUNCE_CYC_DFLT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] func_pos,
  input wire logic func_bank,
  input wire logic paddle_up,
  input wire logic paddle_dn,
  input wire logic remote_lockout_jumper,
  input wire logic detected_625,
  input wire logic reference_present,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rd_data,
  output logic bank_select_led,
  output logic config_activity_led,
  output logic [7:0] fine_delay,
  output logic [10:0] h_delay,
  output logic [9:0] v_delay,
  output logic line_625,
  output logic lock_to_video,
  output logic delay_mode,
  output logic cross_colour_removal,
  output logic test_linearity,
  output logic test_mode,
  output logic freeze_auto,
  output logic freeze_force,
  output logic freeze_field_mode,
  output logic freeze_field2,
  output logic freeze_black
);

  logic [FLG_W-1:0] flags;
  logic [1:0] raw;
  logic [1:0] press;
  logic press_up;
  logic press_dn;
  logic [10:0] hdly_max;
  logic [9:0] vdly_max;
  logic remote_ok;
  logic [BUSY_W-1:0] busy_cnt;

  assign raw = {paddle_dn, paddle_up};
  assign press_up = press[0];
  assign press_dn = press[1];

  // Debounce both paddle contacts; a press is the settled rising edge
  // Settled level and pulse live per contact, so each has one writer
  for (genvar i = 0; i < 2; i++) begin : g_deb
    logic [19:0] cnt;
    logic settled;
    logic pulse;
    always_ff @(posedge clk) begin
      if (reset) begin
        cnt <= 20'h00000;
        settled <= 1'b0;
        pulse <= 1'b0;
      end else begin
        pulse <= 1'b0;
        if (raw[i] == settled) begin
          cnt <= 20'h00000;
        end else if (cnt == 20'(DEBOUNCE_CYC - 1)) begin
          cnt <= 20'h00000;
          settled <= raw[i];
          pulse <= raw[i];
        end else begin
          cnt <= cnt + 20'h00001;
        end
      end
    end
    assign press[i] = pulse;
  end

  assign line_625 = flags[FLG_STD_MANUAL] ? flags[FLG_STD_625] : detected_625;
  assign hdly_max = line_625 ? HDLY_MAX_625 : HDLY_MAX_525;
  assign vdly_max = line_625 ? VDLY_MAX_625 : VDLY_MAX_525;
  // Remote writes refused while the lockout jumper is fitted
  assign remote_ok = wr_strobe && !remote_lockout_jumper;

  // Delay parameters; local paddle takes priority over a remote write
  always_ff @(posedge clk) begin
    if (reset) begin
      fine_delay <= FINE_RST;
      h_delay <= HDLY_RST;
      v_delay <= VDLY_RST;
    end else if (press_dn && !func_bank && func_pos == POS_RECALL) begin
      fine_delay <= FINE_RST;
      h_delay <= HDLY_RST;
      v_delay <= VDLY_RST;
    end else if ((press_up || press_dn) && func_bank) begin
      case (func_pos)
        POS_1: begin
          if (press_up && fine_delay < FINE_MAX) begin
            fine_delay <= fine_delay + 8'h01;
          end else if (press_dn && fine_delay != 8'h00) begin
            fine_delay <= fine_delay - 8'h01;
          end
        end
        POS_2: begin
          if (press_up && h_delay < hdly_max) begin
            h_delay <= h_delay + 11'h001;
          end else if (press_dn && h_delay != 11'h000) begin
            h_delay <= h_delay - 11'h001;
          end
        end
        POS_3: begin
          if (press_up && v_delay < vdly_max) begin
            v_delay <= v_delay + 10'h001;
          end else if (press_dn && v_delay != 10'h000) begin
            v_delay <= v_delay - 10'h001;
          end
        end
        default: begin
        end
      endcase
    end else if (remote_ok) begin
      // Field values above the limit are clamped to it; wr_data bits above the field are dropped
      if (addr == REG_FINE) begin
        fine_delay <= (wr_data[7:0] > FINE_MAX) ? FINE_MAX : wr_data[7:0];
      end else if (addr == REG_HDLY) begin
        h_delay <= (wr_data[10:0] > hdly_max) ? hdly_max : wr_data[10:0];
      end else if (addr == REG_VDLY) begin
        v_delay <= (wr_data[9:0] > vdly_max) ? vdly_max : wr_data[9:0];
      end
    end
  end

  // Two-state settings; position E of bank two falls to default
  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= FLAGS_RST;
    end else if (press_dn && !func_bank && func_pos == POS_RECALL) begin
      flags <= FLAGS_RST;
    end else if ((press_up || press_dn) && func_bank) begin
      case (func_pos)
        POS_0: flags[FLG_LOCK_VIDEO] <= press_up;
        POS_4: flags[FLG_FRZ_AUTO] <= press_dn;
        POS_5: flags[FLG_FRZ_FORCE] <= press_dn;
        POS_6: flags[FLG_FRZ_FIELD] <= press_up;
        POS_7: flags[FLG_FRZ_F2] <= press_dn;
        POS_8: flags[FLG_FRZ_BLACK] <= press_dn;
        POS_A: flags[FLG_XCR] <= press_up;
        POS_C: flags[FLG_TEST_LIN] <= press_dn;
        POS_D: flags[FLG_TEST_EN] <= press_up;
        default: begin
        end
      endcase
    end else if ((press_up || press_dn) && !func_bank) begin
      case (func_pos)
        POS_0: flags[FLG_STD_MANUAL] <= press_dn;
        POS_1: flags[FLG_STD_625] <= press_dn;
        default: begin
        end
      endcase
    end else if (remote_ok && addr == REG_FLAGS) begin
      flags <= wr_data[FLG_W-1:0];
    end
  end

  assign lock_to_video = flags[FLG_LOCK_VIDEO];
  assign cross_colour_removal = flags[FLG_XCR];
  assign test_linearity = flags[FLG_TEST_LIN];
  assign test_mode = flags[FLG_TEST_EN];
  assign freeze_auto = flags[FLG_FRZ_AUTO];
  assign freeze_force = flags[FLG_FRZ_FORCE];
  assign freeze_field_mode = flags[FLG_FRZ_FIELD];
  assign freeze_field2 = flags[FLG_FRZ_F2];
  assign freeze_black = flags[FLG_FRZ_BLACK];
  assign delay_mode = flags[FLG_LOCK_VIDEO] || !reference_present;
  assign bank_select_led = func_bank;

  // Activity LED held for a visible time after init or any change
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_cnt <= BUSY_W'(BUSY_CYC);
    end else if (press_up || press_dn || remote_ok) begin
      busy_cnt <= BUSY_W'(BUSY_CYC);
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - BUSY_W'(1);
    end
  end
  assign config_activity_led = (busy_cnt != '0);

  // Read port: data valid the cycle after the strobe, else zero
  always_ff @(posedge clk) begin
    if (reset || !rd_strobe) begin
      rd_data <= 32'h00000000;
    end else if (addr == REG_FINE) begin
      rd_data <= {24'h000000, fine_delay};
    end else if (addr == REG_HDLY) begin
      rd_data <= {21'h000000, h_delay};
    end else if (addr == REG_VDLY) begin
      rd_data <= {22'h000000, v_delay};
    end else if (addr == REG_FLAGS) begin
      rd_data <= {21'h000000, flags};
    end else if (addr == REG_STATUS) begin
      rd_data <= {24'h000000, remote_lockout_jumper, line_625,
                  config_activity_led, func_bank, func_pos};
    end else begin
      rd_data <= 32'h00000000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_recall;
    press_dn && !func_bank && func_pos == POS_RECALL;
  endsequence
  sequence s_idle_press;
    (press_up || press_dn) && func_bank && func_pos == POS_IDLE
      && !remote_ok;
  endsequence
  sequence s_fine_up;
    press_up && func_bank && func_pos == POS_1 && fine_delay < FINE_MAX;
  endsequence
  sequence s_locked_write;
    wr_strobe && remote_lockout_jumper && !press_up && !press_dn;
  endsequence

  a_fine_range: assert property (fine_delay <= FINE_MAX)
    else $error("fine delay over range");
  a_hdly_range: assert property (h_delay <= HDLY_MAX_625)
    else $error("h delay over range");
  a_vdly_range: assert property (v_delay <= VDLY_MAX_625)
    else $error("v delay over range");
  a_recall_dflt: assert property (s_recall
    |=> fine_delay == FINE_RST && h_delay == HDLY_RST
    && v_delay == VDLY_RST && flags == FLAGS_RST)
    else $error("recall did not restore defaults");
  a_idle_noeff: assert property (s_idle_press |=> $stable(flags)
    && $stable(fine_delay) && $stable(h_delay) && $stable(v_delay))
    else $error("idle position changed settings");
  a_lock_delay: assert property (lock_to_video |-> delay_mode)
    else $error("video lock without delay mode");
  a_press_once: assert property (press_up |=> (!press_up)[*2])
    else $error("paddle press repeated");
  a_lockout_hold: assert property (s_locked_write
    |=> $stable(flags) && $stable(fine_delay) && $stable(h_delay)
    && $stable(v_delay))
    else $error("remote write taken under lockout");
  a_config_activity_led_led: assert property ((press_up || press_dn)
    |=> config_activity_led[*8])
    else $error("activity led not lit after press");
  a_fine_step: assert property (s_fine_up
    |=> fine_delay == $past(fine_delay) + 8'h01)
    else $error("fine delay did not step");
  a_bank_led: assert property (bank_select_led == func_bank)
    else $error("bank led wrong");

endmodule : lcps_store
